// >>> design/tcw_timer.sv
/*
 * 8-bit up/down timer with two compare channels, waveform stage and
 * Wishbone register slave.
 * Assumes one clock (clk_i, 125 MHz), synchronous reset, an external
 * count input that is asynchronous, and port pads that merge the
 * wave outputs and enables.
 */
`timescale 1ns/1ps
module tcw_timer
    import tcw_pkg::*;
(
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire tcw_wb_req_t  wb_i,
    output logic [31:0]       wb_dat_o,
    output logic              wb_ack_o,
    input  wire logic         ext_clk_i,
    input  wire logic [2:0]   irq_ack_i,
    output logic [2:0]        irq_o,
    output logic [1:0]        wave_pin_o,
    output logic [1:0]        wave_oe_o
);

    // ****************************************
    // Register bus decode
    // ****************************************
    logic [2:0]       mode;
    logic [2:0]       cs;
    logic [1:0][1:0]  pin_act;
    logic [7:0]       count;
    logic [2:0]       mask;
    logic             ovf_flag;
    logic [1:0]       port_val;
    logic [1:0]       port_dir;
    tcw_dir_t         dir;
    logic             block;
    logic [PRE_W-1:0] pre;
    logic             ext_s1;
    logic             ext_s2;
    logic             ext_s3;
    logic [1:0]       match_flag;
    logic [1:0][7:0]  cmp_buf;
    logic [1:0][7:0]  cmp_act;
    logic [1:0]       wave;
    logic [1:0]       hit;

    wire       bus_req  = wb_i.cyc & wb_i.stb & ~wb_ack_o;
    wire       bus_wr   = bus_req & wb_i.we & wb_i.sel[0];
    wire [7:0] wdat     = wb_i.dat[7:0];
    wire       sel_ca   = wb_i.adr == ADR_CTRL_A;
    wire       sel_cb   = wb_i.adr == ADR_CTRL_B;
    wire       sel_cnt  = wb_i.adr == ADR_COUNT;
    wire       sel_ma   = wb_i.adr == ADR_CMP_A;
    wire       sel_mb   = wb_i.adr == ADR_CMP_B;
    wire       sel_msk  = wb_i.adr == ADR_INT_MASK;
    wire       sel_flg  = wb_i.adr == ADR_INT_FLAG;
    wire       sel_port = wb_i.adr == ADR_PORT;
    wire       wr_ca    = bus_wr & sel_ca;
    wire       wr_cb    = bus_wr & sel_cb;
    wire       wr_count = bus_wr & sel_cnt;
    wire       wr_flg   = bus_wr & sel_flg;
    wire [1:0] wr_cmp   = {bus_wr & sel_mb, bus_wr & sel_ma};

    // Unmapped addresses are acknowledged and read as zero
    wire [7:0] rd_byte =
        sel_ca   ? {pin_act[0], pin_act[1], 2'h0, mode[1:0]} :
        sel_cb   ? {4'h0, mode[2], cs} :
        sel_cnt  ? count :
        sel_ma   ? cmp_buf[0] :
        sel_mb   ? cmp_buf[1] :
        sel_msk  ? {5'h0, mask} :
        sel_flg  ? {5'h0, match_flag, ovf_flag} :
        sel_port ? {4'h0, port_dir, port_val} :
        RST_BYTE;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= {24'h00_0000, rd_byte};
        end
    end

    // ****************************************
    // Control registers
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode     <= MODE_NORMAL;
            cs       <= CS_STOP;
            pin_act  <= '0;
            mask     <= 3'h0;
            port_val <= 2'h0;
            port_dir <= 2'h0;
        end else begin
            if (wr_ca) begin
                mode[1:0]  <= wdat[1:0];
                pin_act[0] <= wdat[7:6];
                pin_act[1] <= wdat[5:4];
            end
            if (wr_cb) begin
                mode[2] <= wdat[CB_MODE2];
                cs      <= wdat[2:0];
            end
            if (bus_wr & sel_msk)
                mask <= wdat[2:0];
            if (bus_wr & sel_port) begin
                port_val <= wdat[1:0];
                port_dir <= wdat[3:2];
            end
        end
    end

    // ****************************************
    // Timer tick selection
    // ****************************************
    // External input is synchronised; only the second and third stages
    // feed the edge detector, so its rate must stay below clk_i / 2.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pre    <= '0;
            ext_s1 <= 1'b0;
            ext_s2 <= 1'b0;
            ext_s3 <= 1'b0;
        end else begin
            pre    <= pre + PRE_ONE;
            ext_s1 <= ext_clk_i;
            ext_s2 <= ext_s1;
            ext_s3 <= ext_s2;
        end
    end

    wire ext_rise = ext_s2 & ~ext_s3;
    wire ext_fall = ~ext_s2 & ext_s3;
    wire tick =
        ((cs == CS_DIV1)) |
        ((cs == CS_DIV8)     & (&pre[PRE8_BITS-1:0])) |
        ((cs == CS_DIV64)    & (&pre[PRE64_BITS-1:0])) |
        ((cs == CS_DIV256)   & (&pre[PRE256_BITS-1:0])) |
        ((cs == CS_DIV1024)  & (&pre)) |
        ((cs == CS_EXT_FALL) & ext_fall) |
        ((cs == CS_EXT_RISE) & ext_rise);

    // ****************************************
    // Counter unit
    // ****************************************
    wire       is_pwm    = mode[0];
    wire       is_dual   = (mode == MODE_PC_FF) | (mode == MODE_PC_A);
    wire       is_fast   = (mode == MODE_FP_FF) | (mode == MODE_FP_A);
    wire       is_clr    = mode == MODE_CLR;
    wire       top_is_a  = is_clr | (mode == MODE_PC_A) | (mode == MODE_FP_A);
    wire [7:0] top       = top_is_a ? cmp_act[0] : CNT_MAX;
    wire       at_top    = count == top;
    wire       at_bottom = count == CNT_BOTTOM;
    wire       step      = tick & ~wr_count;
    wire       clear_now = (is_clr | is_fast) & at_top;
    wire       go_down   = is_dual &
                           ((dir == TCW_DOWN) ? ~at_bottom : at_top);
    wire       turn_down = is_dual & (dir == TCW_UP) & at_top;
    wire       turn_up   = is_dual & (dir == TCW_DOWN) & at_bottom;
    wire [7:0] cnt_inc   = count + CNT_ONE;
    wire [7:0] cnt_dec   = count - CNT_ONE;
    wire [7:0] next_count =
        wr_count  ? wdat :
        ~tick     ? count :
        clear_now ? CNT_BOTTOM :
        go_down   ? cnt_dec : cnt_inc;
    wire ovf_set = step & (is_dual ? turn_up :
                   is_fast ? at_top : (count == CNT_MAX));
    // Buffered compare values move in at bottom (fast) or top (dual)
    wire cmp_upd = step & ((is_fast & at_top) | turn_down);
    wire flag_clr_ovf = (wr_flg & wdat[INT_OVF]) | irq_ack_i[INT_OVF];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count    <= RST_BYTE;
            dir      <= TCW_UP;
            block    <= 1'b0;
            ovf_flag <= 1'b0;
        end else begin
            count <= next_count;
            if (step)
                dir <= turn_down ? TCW_DOWN :
                       (turn_up | ~is_dual) ? TCW_UP : dir;
            // Only a tick consumes the block, so a write while
            // stopped still guards the first match after restart
            block <= wr_count | (block & ~tick);
            // A set in the same cycle as a clear wins
            ovf_flag <= ovf_set | (ovf_flag & ~flag_clr_ovf);
        end
    end

    // ****************************************
    // Compare channels and waveform stage
    // ****************************************
    for (genvar ch = 0; ch < 2; ch++) begin : g_ch
        wire [1:0] act     = pin_act[ch];
        wire       eq      = count == cmp_act[ch];
        wire       force_s = wr_cb & wdat[CB_FORCE_A - ch] & ~is_pwm;
        wire       np_ev   = ~is_pwm & (hit[ch] | force_s)
                             & (act != ACT_NONE);
        wire       np_val  = (act == ACT_TOGGLE) ? ~wave[ch]
                                                  : (act == ACT_SET);
        wire       p_tog   = is_pwm & hit[ch] & (act == ACT_TOGGLE)
                             & (ch == 0) & mode[2];
        wire       p_cmp   = is_pwm & hit[ch] & act[1];
        wire       p_val   = is_fast ? act[0]
                                     : ((dir == TCW_DOWN) ^ act[0]);
        // Bottom action lands on the tick that wraps the count
        wire       p_bot   = is_fast & act[1] & step & at_top;
        wire       next_wave =
            np_ev ? np_val :
            p_bot ? ~act[0] :
            p_tog ? ~wave[ch] :
            p_cmp ? p_val : wave[ch];
        wire       flag_clr = (wr_flg & wdat[INT_A + ch])
                              | irq_ack_i[INT_A + ch];

        assign hit[ch] = tick & eq & ~block;

        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                cmp_buf[ch]    <= RST_BYTE;
                cmp_act[ch]    <= RST_BYTE;
                wave[ch]       <= 1'b0;
                match_flag[ch] <= 1'b0;
                wave_pin_o[ch] <= 1'b0;
                wave_oe_o[ch]  <= 1'b0;
            end else begin
                if (wr_cmp[ch])
                    cmp_buf[ch] <= wdat;
                if (wr_cmp[ch] & ~is_pwm)
                    cmp_act[ch] <= wdat;
                else if (cmp_upd)
                    cmp_act[ch] <= cmp_buf[ch];
                wave[ch]       <= next_wave;
                match_flag[ch] <= hit[ch]
                                  | (match_flag[ch] & ~flag_clr);
                wave_pin_o[ch] <= (act != ACT_NONE) ? wave[ch]
                                                    : port_val[ch];
                // Direction stays with the port during override
                wave_oe_o[ch]  <= port_dir[ch];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i)
            irq_o <= 3'h0;
        else
            irq_o <= {match_flag, ovf_flag} & mask;
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Channel A force strobe as the waveform stage sees it
    wire force_s_any = wr_cb & ~is_pwm & wdat[CB_FORCE_A];

    AST_HALT: assert property ((cs == CS_STOP) && !wr_count
        |=> count == $past(count))
        else $error("counter moved while halted");

    AST_WRITE_WINS: assert property (wr_count
        |=> count == $past(wdat))
        else $error("counter write did not take priority");

    AST_NORMAL_WRAP: assert property ((mode == MODE_NORMAL)
        && step && (count == CNT_MAX) |=> count == CNT_BOTTOM)
        else $error("normal mode did not wrap to zero");

    AST_OVF_SET: assert property ((mode == MODE_NORMAL) && step
        && (count == CNT_MAX) |=> ovf_flag && (count == CNT_BOTTOM))
        else $error("overflow flag not set on wrap");

    AST_BLOCK: assert property (block && tick
        && (match_flag == 2'h0) |=> match_flag == 2'h0)
        else $error("match not blocked after counter write");

    AST_FLAG_SET: assert property (hit[0] |=> match_flag[0])
        else $error("match flag A not set by match");

    AST_FORCE_NOFLAG: assert property (!hit[1] && !match_flag[1]
        |=> !match_flag[1])
        else $error("match flag B set without a match");

    AST_CLR_TOP: assert property (is_clr && step
        && (count == cmp_act[0]) |=> count == CNT_BOTTOM)
        else $error("clear mode did not clear at compare A");

    AST_FAST_TOP: assert property ((mode == MODE_FP_FF) && step
        && (count == CNT_MAX) |=> count == CNT_BOTTOM)
        else $error("fast mode did not restart at top");

    AST_DUAL_TOP: assert property ((mode == MODE_PC_FF) && step
        && (dir == TCW_UP) && (count == CNT_MAX)
        |=> (count == 8'hfe) && (dir == TCW_DOWN))
        else $error("dual-slope did not turn at top");

    AST_BUFFERED: assert property (is_pwm && wr_cmp[1] && !cmp_upd
        |=> $stable(cmp_act[1]))
        else $error("buffered compare value changed early");

    AST_DIRECT: assert property (!is_pwm && wr_cmp[0]
        |=> cmp_act[0] == $past(wdat))
        else $error("direct compare write not applied");

    AST_NO_ACTION: assert property (pin_act[0] == ACT_NONE
        |=> $stable(wave[0]))
        else $error("output state changed with no pin action");

    AST_OVERRIDE: assert property ((pin_act[1] != ACT_NONE)
        |=> wave_pin_o[1] == $past(wave[1]))
        else $error("pin not overridden by output state");

    AST_DIRECT_B: assert property (!is_pwm && wr_cmp[1]
        |=> cmp_act[1] == $past(wdat))
        else $error("direct compare B write not applied");

    AST_FP_A_TOP: assert property ((mode == MODE_FP_A)
        && step && (count == cmp_act[0])
        |=> count == CNT_BOTTOM)
        else $error("fast mode did not restart at compare A");

    AST_DUAL_UP: assert property (is_dual && step
        && (dir == TCW_DOWN) && (count == CNT_BOTTOM)
        |=> (count == CNT_ONE) && (dir == TCW_UP) && ovf_flag)
        else $error("dual-slope did not turn at bottom");

    AST_DUAL_DOWN: assert property (is_dual && step
        && (dir == TCW_DOWN) && (count != CNT_BOTTOM)
        |=> count == $past(count) - CNT_ONE)
        else $error("dual-slope did not count down");

    AST_NORMAL_UP: assert property ((mode == MODE_NORMAL)
        && step && (count != CNT_MAX)
        |=> count == $past(count) + CNT_ONE)
        else $error("normal mode did not count up");

    AST_FLAG_CLR: assert property (match_flag[0] && !hit[0]
        && (irq_ack_i[INT_A] || (wr_flg && wdat[INT_A]))
        |=> !match_flag[0])
        else $error("match flag A not cleared");

    AST_IRQ_A: assert property (match_flag[0] && mask[INT_A]
        |=> irq_o[INT_A])
        else $error("enabled match flag A raised no request");

    AST_KEEP_STATE: assert property ((wr_ca || wr_cb) && !tick
        && !force_s_any
        |=> $stable(wave[0]))
        else $error("output state changed on a control write");

    AST_DIR_PIN: assert property (!rst_i
        |=> wave_oe_o == $past(port_dir))
        else $error("pin enable does not follow port direction");

    AST_FORCE_B: assert property (wr_cb && wdat[CB_FORCE_A - 1]
        && !is_pwm && !tick && (pin_act[1] == ACT_TOGGLE)
        |=> wave[1] != $past(wave[1]))
        else $error("force strobe B did not toggle output");

    COV_CLR_WRAP: cover property (is_clr && step && clear_now);
    COV_DUAL_TURN: cover property (turn_down ##[1:600] turn_up);
    COV_FORCE: cover property (force_s_any ##1 $changed(wave));
    COV_BLOCKED: cover property (block && tick && (count == cmp_act[0]));
    COV_DUAL_OVF: cover property (is_dual && ovf_set);

endmodule : tcw_timer

// >>> design/tcw_pkg.sv
/*
 * Constants, types and register map of the 8-bit timer with two compare
 * channels and waveform outputs.
 * Assumes a classic Wishbone master with 32-bit data; registers are
 * 8 bits wide in the low byte of each aligned word.
 */
// Operation
// - Each timer tick clears, increments or decrements counter
// - Clock source select zero halts the counter
// - Counter readable and writable at all times
// - Counter write beats clear and count
// - Three-bit waveform mode split across two control registers
// - Counter continuously compared with both compare values
// - Match sets flag; enabled flag requests interrupt
// - Flag clears on service or written one
// - PWM modes buffer compare writes until top/bottom
// - Non-PWM modes write compare value directly
// - Force strobe changes output only, not flag
// - Counter write blocks matches for next tick
// - Output state survives mode change; reset clears
// - Pin action changes act at next match
// - Nonzero pin action overrides port value
// - Pin action zero leaves output state alone
// - Pin action selects polarity or set/clear/toggle
// - Mode 0 counts up, wraps 0xff to 0x00
// - Mode 0 overflow flag set when counter wraps
// - Mode 2 clears counter at compare value A
// - Modes 3/7 single-slope, top 0xff or A
// - Modes 1/5 dual-slope, top 0xff or A
package tcw_pkg;

    // ****************************************
    // Register map (byte addresses)
    // ****************************************
    localparam logic [5:0] ADR_CTRL_A   = 6'h00;
    localparam logic [5:0] ADR_CTRL_B   = 6'h04;
    localparam logic [5:0] ADR_COUNT    = 6'h08;
    localparam logic [5:0] ADR_CMP_A    = 6'h0c;
    localparam logic [5:0] ADR_CMP_B    = 6'h10;
    localparam logic [5:0] ADR_INT_MASK = 6'h14;
    localparam logic [5:0] ADR_INT_FLAG = 6'h18;
    localparam logic [5:0] ADR_PORT     = 6'h1c;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int CB_FORCE_A = 7;
    localparam int CB_MODE2   = 3;
    localparam int INT_OVF    = 0;
    localparam int INT_A      = 1;

    // ****************************************
    // Values
    // ****************************************
    localparam logic [7:0] RST_BYTE   = 8'h00;
    localparam logic [7:0] CNT_BOTTOM = 8'h00;
    localparam logic [7:0] CNT_MAX    = 8'hff;
    localparam logic [7:0] CNT_ONE    = 8'h01;
    localparam logic [9:0] PRE_ONE    = 10'h001;

    localparam logic [2:0] MODE_NORMAL = 3'h0;
    localparam logic [2:0] MODE_CLR    = 3'h2;
    localparam logic [2:0] MODE_PC_FF  = 3'h1;
    localparam logic [2:0] MODE_PC_A   = 3'h5;
    localparam logic [2:0] MODE_FP_FF  = 3'h3;
    localparam logic [2:0] MODE_FP_A   = 3'h7;

    localparam logic [1:0] ACT_NONE   = 2'h0;
    localparam logic [1:0] ACT_TOGGLE = 2'h1;
    localparam logic [1:0] ACT_SET    = 2'h3;

    localparam logic [2:0] CS_STOP     = 3'h0;
    localparam logic [2:0] CS_DIV1     = 3'h1;
    localparam logic [2:0] CS_DIV8     = 3'h2;
    localparam logic [2:0] CS_DIV64    = 3'h3;
    localparam logic [2:0] CS_DIV256   = 3'h4;
    localparam logic [2:0] CS_DIV1024  = 3'h5;
    localparam logic [2:0] CS_EXT_FALL = 3'h6;
    localparam logic [2:0] CS_EXT_RISE = 3'h7;

    // Prescaler taps: number of low counter bits that must all be one
    localparam int PRE_W       = 10;
    localparam int PRE8_BITS   = 3;
    localparam int PRE64_BITS  = 6;
    localparam int PRE256_BITS = 8;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic {TCW_UP, TCW_DOWN} tcw_dir_t;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [5:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } tcw_wb_req_t;

endpackage : tcw_pkg

// >>> testbench/tcw_host_model.sv
/*
 * Far-side model: external count source and interrupt service.
 * Assumes the bench's clock and synchronous reset; the count input stands
 * low between bursts, and interrupts are serviced only while enabled.
 */
`timescale 1ns/1ps
module tcw_host_model
    import tcw_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       start_i,
    input  wire logic [8:0] edges_i,
    input  wire logic       svc_en_i,
    input  wire logic [2:0] irq_i,
    output logic            ext_clk_o,
    output logic [2:0]      irq_ack_o,
    output logic            busy_o
);
    logic [8:0] left;
    logic [2:0] ph;
    logic [1:0] svc_cnt;

    // ****************************************
    // Count bursts, eight clocks per edge
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            left      <= 9'h000;
            ph        <= 3'h0;
            busy_o    <= 1'b0;
            ext_clk_o <= 1'b0;
        end else if (start_i && !busy_o) begin
            left   <= edges_i;
            ph     <= 3'h0;
            busy_o <= (edges_i != 9'h000);
        end else if (busy_o) begin
            ph <= ph + 3'h1;
            if (ph == 3'h3) begin
                ext_clk_o <= 1'b1;
            end
            if (ph == 3'h7) begin
                ext_clk_o <= 1'b0;
                left      <= left - 9'h001;
                busy_o    <= (left != 9'h001);
            end
        end
    end

    // ****************************************
    // Slow interrupt service: ack after four cycles
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            svc_cnt   <= 2'h0;
            irq_ack_o <= 3'h0;
        end else begin
            irq_ack_o <= 3'h0;
            if (svc_en_i && irq_i != 3'h0) begin
                svc_cnt <= svc_cnt + 2'h1;
                if (svc_cnt == 2'h3) begin
                    irq_ack_o <= irq_i;
                end
            end else begin
                svc_cnt <= 2'h0;
            end
        end
    end
endmodule : tcw_host_model

// >>> testbench/tcw_timer_tb.sv
/*
 * Self-checking bench for the timer: register reads are noted in a queue
 * and compared by a monitor at each ack.
 * Assumes the host model supplies count edges and interrupt service.
 */
`timescale 1ns/1ps
module tcw_timer_tb
    import tcw_pkg::*;
;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    tcw_wb_req_t req   = '0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o, ext_clk, busy, start = 1'b0, svc = 1'b0;
    logic [2:0]  irq_ack, irq_o;
    logic [1:0]  wave_pin_o, wave_oe_o;
    logic [8:0]  nedge = 9'h000;
    logic [8:0]  exp_q [$];
    logic [8:0]  e;
    logic [7:0]  rv;
    int          errors = 0;
    int          num_checks = 0;
    logic [2:0] md [6] = '{MODE_NORMAL, MODE_CLR, MODE_FP_FF, MODE_FP_A,
                           MODE_PC_A, MODE_PC_FF};
    logic [7:0] cw [6] = '{8'h10, 8'h10, 8'h10, 8'h20, 8'h10, 8'h10};
    logic [7:0] ct [6] = '{8'hfd, 8'h00, 8'hfe, 8'h0e, 8'h0e, 8'hfd};
    logic [8:0] np [6] = '{9'h005, 9'h014, 9'h004, 9'h004, 9'h014, 9'h005};
    logic [7:0] ec [6] = '{8'h02, 8'h03, 8'h02, 8'h01, 8'h02, 8'hfc};
    logic [7:0] ef [6] = '{8'h01, 8'h02, 8'h01, 8'h03, 8'h03, 8'h00};
    logic [7:0] ca [9] = '{8'h40, 8'h40, 8'hc0, 8'hc0, 8'h80, 8'h00,
                           8'hc0, 8'hc0, 8'hc3};
    logic       fo [9] = '{1, 1, 1, 1, 1, 1, 0, 1, 0};
    logic       ep [9] = '{1, 0, 1, 1, 0, 1, 0, 1, 1};

    always #4 clk_i = ~clk_i;

    tcw_timer tcw_timer_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_i(req),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_clk_i(ext_clk),
        .irq_ack_i(irq_ack), .irq_o(irq_o), .wave_pin_o(wave_pin_o),
        .wave_oe_o(wave_oe_o));
    tcw_host_model tcw_host_model_inst (.clk_i(clk_i), .rst_i(rst_i),
        .start_i(start), .edges_i(nedge), .svc_en_i(svc), .irq_i(irq_o),
        .ext_clk_o(ext_clk), .irq_ack_o(irq_ack), .busy_o(busy));

    // ****************************************
    // Closing report and checks
    // ****************************************
    task automatic results();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : results

    task automatic chk(input string nm, input logic [7:0] x, input logic [7:0] g);
        num_checks++;
        if (g !== x) begin
            errors++;
            $display("ERROR %s expected %h seen %h", nm, x, g);
        end
    endtask : chk

    always @(posedge clk_i) begin
        if (wb_ack_o === 1'b1) begin
            if (exp_q.size() == 0) begin
                errors++;
                $display("ERROR wb_ack_o expected 0 seen 1");
            end else begin
                e = exp_q.pop_front();
                if (e[8]) begin
                    num_checks++;
                    if (wb_dat_o !== {24'h0, e[7:0]}) begin
                        errors++;
                        $display("ERROR wb_dat_o expected %h seen %h",
                                 e[7:0], wb_dat_o);
                    end
                end
            end
        end
    end

    // ****************************************
    // Bus and count-source drivers
    // ****************************************
    // Read data is never driven meaningfully; the expected byte rides along
    task automatic wb(input logic w, input logic [5:0] a, input logic [7:0] d,
                      input logic c);
        int n;
        @(posedge clk_i);
        req <= '{1'b1, 1'b1, w, a, 4'h1, {24'h0, d}};
        exp_q.push_back({c, d});
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        req.cyc <= 1'b0;
        req.stb <= 1'b0;
        if (n >= 20) begin
            errors++;
            $display("ERROR wb_ack_o timeout");
            results();
        end
    endtask : wb

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        wb(1'b1, a, d, 1'b0);
    endtask : wr

    task automatic rd(input logic [5:0] a, input logic [7:0] x);
        wb(1'b0, a, x, 1'b1);
    endtask : rd

    // Fixed settle: the tick lands about three clocks after a pad edge
    task automatic pulses(input logic [8:0] n);
        int k;
        @(posedge clk_i);
        start <= 1'b1;
        nedge <= n;
        @(posedge clk_i);
        start <= 1'b0;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (busy !== 1'b0 && k < 4000);
        repeat (8) @(posedge clk_i);
        if (k >= 4000) begin
            errors++;
            $display("ERROR busy timeout");
            results();
        end
    endtask : pulses

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        rv = 8'($urandom(65840));
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int a = 0; a < 9; a++) begin
            rd(6'(a * 4), RST_BYTE);
        end
        chk("wave_pin_o", 8'h00, {6'h0, wave_pin_o});
        $display("test reset done");
        wr(ADR_COUNT, rv);
        rd(ADR_COUNT, rv);
        repeat (16) @(posedge clk_i);
        rd(ADR_COUNT, rv);
        $display("test stopped access done");
        // no compare output is in use while matching values are written
        wr(ADR_CMP_A, 8'h40);
        wr(ADR_CMP_B, 8'h80);
        wr(ADR_COUNT, 8'h40);
        wr(ADR_INT_FLAG, 8'h07);
        rd(ADR_INT_FLAG, 8'h00);
        wr(ADR_CTRL_B, {5'h0, CS_EXT_RISE});
        pulses(9'h002);
        rd(ADR_INT_FLAG, 8'h00);
        rd(ADR_COUNT, 8'h42);
        wr(ADR_COUNT, 8'h3f);
        pulses(9'h002);
        rd(ADR_INT_FLAG, 8'h02);
        $display("test match blocking done");
        for (int i = 0; i < 6; i++) begin
            wr(ADR_CTRL_B, 8'h00);
            wr(ADR_CTRL_A, 8'h00);
            wr(ADR_CMP_A, 8'h10);
            wr(ADR_CTRL_A, {6'h0, md[i][1:0]});
            wr(ADR_CTRL_B, {4'h0, md[i][2], CS_STOP});
            wr(ADR_CMP_A, cw[i]);
            wr(ADR_CMP_B, {5'h12, md[i]});
            wr(ADR_COUNT, ct[i]);
            wr(ADR_INT_FLAG, 8'h07);
            wr(ADR_CTRL_B, {4'h0, md[i][2], CS_EXT_RISE});
            pulses(np[i]);
            rd(ADR_COUNT, ec[i]);
            rd(ADR_CMP_A, cw[i]);
            rd(ADR_INT_FLAG, ef[i]);
            $display("test mode %0d done", md[i]);
        end
        wr(ADR_CTRL_B, 8'h00);
        wr(ADR_PORT, 8'h01);
        for (int i = 0; i < 9; i++) begin
            wr(ADR_CTRL_A, ca[i]);
            wr(ADR_CTRL_B, {fo[i], 7'h0});
            repeat (2) @(posedge clk_i);
            chk("wave_pin_o[0]", {7'h0, ep[i]}, {7'h0, wave_pin_o[0]});
        end
        rd(ADR_INT_FLAG, 8'h00);
        rd(ADR_COUNT, 8'hfc);
        wr(ADR_PORT, 8'h06);
        repeat (2) @(posedge clk_i);
        chk("wave_oe_o", 8'h01, {6'h0, wave_oe_o});
        chk("wave_pin_o", 8'h03, {6'h0, wave_pin_o});
        wr(ADR_CTRL_A, 8'hd0);
        repeat (2) @(posedge clk_i);
        chk("wave_pin_o", 8'h01, {6'h0, wave_pin_o});
        wr(ADR_CTRL_B, 8'h40);
        repeat (2) @(posedge clk_i);
        chk("wave_pin_o", 8'h03, {6'h0, wave_pin_o});
        $display("test wave output done");
        wr(ADR_CTRL_A, 8'h00);
        wr(ADR_CTRL_B, {5'h0, CS_EXT_FALL});
        wr(ADR_INT_MASK, 8'h02);
        wr(ADR_COUNT, 8'h0e);
        pulses(9'h004);
        rd(ADR_INT_FLAG, 8'h02);
        chk("irq_o", 8'h02, {5'h0, irq_o});
        svc <= 1'b1;
        repeat (12) @(posedge clk_i);
        rd(ADR_INT_FLAG, 8'h00);
        chk("irq_o", 8'h00, {5'h0, irq_o});
        $display("test interrupt service done");
        results();
    end
endmodule : tcw_timer_tb
